// ---- src/storage_protect_map.svh ----
`ifndef STORAGE_PROTECT_MAP_SVH
`define STORAGE_PROTECT_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SP_OFF_CTRL 12'h000
`define SP_OFF_CARE 12'h004
`define SP_OFF_VALUE 12'h008
`define SP_OFF_STATUS 12'h00c
`define SP_OFF_MASK 12'h010
`define SP_OFF_INFO 12'h014

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SP_CTRL_SEL_EN_BIT 0
`define SP_ST_ILLEGAL_BIT 5
`define SP_ST_FORCE_BIT 6
`define SP_ST_WIDTH 7
`define SP_INFO_CAP_LSB 16

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SP_CTRL_RST 1'b0
`define SP_CARE_RST 15'h0000
`define SP_VALUE_RST 15'h0000
`define SP_MASK_RST 7'h00

// ------------------------------------------------------------
// Address constants (15-bit word addresses)
// ------------------------------------------------------------
`define SP_ADDR_AUTO_LOAD 15'h7fe0
`define SP_ADDR_AUTO_DUMP 15'h7ff0
`define SP_TOP_BLOCK_LSB 5
`define SP_SAVE_LO 15'h0002
`define SP_SAVE_HI 15'h0005
`define SP_SAVE_A 15'h0008
`define SP_SAVE_B 15'h0009
`define SP_CAP_8K 2'h0
`define SP_CAP_16K 2'h1
`define SP_CAP_32K 2'h2

`endif

// ---- src/storage_protect_pkg.sv ----
package storage_protect_pkg;

	// Storage request as presented on the address bus
	typedef struct packed {
		logic valid;
		logic write;
		logic [14:0] addr;
	} stor_req_t;

	// Three-state pattern: care bit set means the value bit must match
	typedef struct packed {
		logic [14:0] care;
		logic [14:0] value;
	} pattern_t;

	// Bus data-phase bookkeeping
	typedef struct packed {
		logic wr;
		logic [11:0] addr;
	} bus_phase_t;

endpackage

// ---- src/protect_check.sv ----
`include "storage_protect_map.svh"

// Combinational protection decision for one storage address
module protect_check (
	input wire storage_protect_pkg::stor_req_t req, // Raw request
	input wire logic [1:0] cap_sel, // Detected capacity
	input wire storage_protect_pkg::pattern_t pattern, // Selective pattern
	input wire logic sel_active, // Selective protection in force
	input wire logic auto_enter, // Enter-auto-program held
	input wire logic int_seq, // Interrupt sequence running
	output logic [14:0] adj_addr, // Address folded into capacity
	output logic blocked // Write must be suppressed
);
	logic [14:0] cap_mask;
	logic top_hit;
	logic sel_hit;
	logic save_hit;

	// Fold the upper digit down to the installed memory, then test
	always_comb begin
		case (cap_sel)
			`SP_CAP_8K: cap_mask = 15'h1fff;
			`SP_CAP_16K: cap_mask = 15'h3fff;
			default: cap_mask = 15'h7fff;
		endcase
		adj_addr = req.addr & cap_mask;
		// Top 32 words: every bit above the low five is at its capacity maximum
		top_hit = &(adj_addr[14:`SP_TOP_BLOCK_LSB] | ~cap_mask[14:`SP_TOP_BLOCK_LSB]);
		sel_hit = ((adj_addr ^ pattern.value) & pattern.care) == 15'h0000;
		save_hit = int_seq && (((adj_addr >= `SP_SAVE_LO) && (adj_addr <= `SP_SAVE_HI))
			|| (adj_addr == `SP_SAVE_A) || (adj_addr == `SP_SAVE_B));
		blocked = req.valid && req.write && !save_hit
			&& ((top_hit && !auto_enter) || (sel_hit && sel_active));
	end
endmodule

// ---- src/storage_protect.sv ----
`include "storage_protect_map.svh"

// Behaviour
// - Protected writes are dropped silently; execution never stops or traps.
// - A blocked write sets the illegal-write flag, shown as status bit 05.
// - Flag clears on master clear, internal clear or a status read.
// - Top 32 words of installed memory are always protected.
// - Every bus address is checked; reads pass, only writes are blocked.
// - Enter-auto-program lifts the top-block protection while held.
// - Fifteen three-state pattern settings, one per address bit.
// - Pattern matches when every one/zero bit agrees; neutral bits match anything.
// - All-neutral pattern with selective protection on protects every address.
// - Console disable turns off selective protection only.
// - During interrupt sequence, 00002-00005, 00010, 00011 are always writable.
// - Auto load forces the program address to 77740.
// - Auto dump forces the program address to 77760.
// - Over-capacity addresses fold their top digit; check uses folded address.
module storage_protect (
	input wire logic hclk, // Bus clock
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [11:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write transfer
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready in
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire storage_protect_pkg::stor_req_t stor_in, // Request from requesters
	input wire logic int_seq, // Interrupt sequence in progress
	input wire logic [1:0] cap_sel, // Detected storage capacity
	input wire logic console_disable, // Disable storage protect switch
	input wire logic auto_enter, // Enter auto program switch
	input wire logic auto_load, // Auto load switch
	input wire logic auto_dump, // Auto dump switch
	input wire logic master_clear, // Master clear pulse
	input wire logic internal_clear, // Internal clear pulse
	output storage_protect_pkg::stor_req_t stor_out, // Request passed to storage
	output logic illegal_lamp, // Console indicator
	output logic p_force_valid, // Load program address
	output logic [14:0] p_force_addr, // Forced program address
	output logic irq // Level interrupt
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Decodes a bus offset against one register; used by reads and writes
	// Exact compare of all twelve bits, so unmapped offsets fall through
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	// ------------------------------------------------------------
	// Protection check
	// ------------------------------------------------------------

	// Enable and pattern are kept by the configuration registers below
	logic sel_en;
	storage_protect_pkg::pattern_t pattern;
	logic [14:0] adj_addr;
	logic blocked;
	logic sel_active;

	// Console disable gates the pattern path only; the top block stays guarded
	assign sel_active = sel_en && !console_disable;

	// Decision is combinational so a blocked write never reaches storage
	protect_check u_check (
		.req(stor_in),
		.cap_sel(cap_sel),
		.pattern(pattern),
		.sel_active(sel_active),
		.auto_enter(auto_enter),
		.int_seq(int_seq),
		.adj_addr(adj_addr),
		.blocked(blocked)
	);

	// ------------------------------------------------------------
	// Storage path
	// ------------------------------------------------------------

	storage_protect_pkg::stor_req_t next_stor_out;

	// Blocked writes go out as reads so the cycle still restores the core
	// Trade-off: one cycle of latency buys a clean registered request
	always_comb begin
		next_stor_out.valid = stor_in.valid;
		next_stor_out.write = stor_in.write && !blocked;
		next_stor_out.addr = adj_addr;
	end

	// Register the request handed to storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stor_out <= '0;
		end else begin
			stor_out <= next_stor_out;
		end
	end

	// ------------------------------------------------------------
	// Auto load and auto dump
	// ------------------------------------------------------------

	logic load_q;
	logic dump_q;
	logic next_p_force_valid;
	logic [14:0] next_p_force_addr;
	logic force_evt;

	// Edge detect so a held switch forces the address only once
	// Load wins when both switches rise in the same cycle
	always_comb begin
		next_p_force_valid = 1'b0;
		next_p_force_addr = p_force_addr;
		if (auto_load && !load_q) begin
			next_p_force_valid = 1'b1;
			next_p_force_addr = `SP_ADDR_AUTO_LOAD;
		end else if (auto_dump && !dump_q) begin
			next_p_force_valid = 1'b1;
			next_p_force_addr = `SP_ADDR_AUTO_DUMP;
		end
		force_evt = next_p_force_valid;
	end

	// Switch history resets to the idle level, so reset gives no false edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			load_q <= 1'b0;
			dump_q <= 1'b0;
			p_force_valid <= 1'b0;
			p_force_addr <= 15'h0000;
		end else begin
			load_q <= auto_load;
			dump_q <= auto_dump;
			p_force_valid <= next_p_force_valid;
			p_force_addr <= next_p_force_addr;
		end
	end

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------

	// Address-phase fields parked for the data phase that follows
	storage_protect_pkg::bus_phase_t dph;
	storage_protect_pkg::bus_phase_t next_dph;
	logic dph_valid;
	logic next_dph_valid;
	logic take;
	logic rd_take;
	logic [31:0] next_hrdata;
	logic [`SP_ST_WIDTH-1:0] status;
	logic [`SP_ST_WIDTH-1:0] mask;
	logic [14:0] last_blocked;

	// Zero wait states: hreadyout stays high, so every phase is one cycle
	// No error case exists, so the response stays OKAY
	always_comb begin
		take = hsel && htrans[1] && hready;
		rd_take = take && !hwrite;
		next_dph_valid = take && hwrite;
		next_dph.wr = hwrite;
		next_dph.addr = haddr;
		next_hrdata = 32'h0000_0000;
		if (rd_take) begin
			if (hit(haddr, `SP_OFF_CTRL)) begin
				next_hrdata[`SP_CTRL_SEL_EN_BIT] = sel_en;
			end else if (hit(haddr, `SP_OFF_CARE)) begin
				next_hrdata[14:0] = pattern.care;
			end else if (hit(haddr, `SP_OFF_VALUE)) begin
				next_hrdata[14:0] = pattern.value;
			end else if (hit(haddr, `SP_OFF_STATUS)) begin
				// The pre-clear value is returned; the sense clears the flag after
				next_hrdata[`SP_ST_WIDTH-1:0] = status;
			end else if (hit(haddr, `SP_OFF_MASK)) begin
				next_hrdata[`SP_ST_WIDTH-1:0] = mask;
			end else if (hit(haddr, `SP_OFF_INFO)) begin
				// Last blocked folded address and the detected capacity
				next_hrdata[14:0] = last_blocked;
				next_hrdata[`SP_INFO_CAP_LSB+1:`SP_INFO_CAP_LSB] = cap_sel;
			end
		end
	end

	// Ready comes up at the first edge after reset and then stays high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph <= '0;
			dph_valid <= 1'b0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			dph <= next_dph;
			dph_valid <= next_dph_valid;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------

	logic next_sel_en;
	storage_protect_pkg::pattern_t next_pattern;
	logic [`SP_ST_WIDTH-1:0] next_mask;

	// Operator settings survive master clear; only power-on reset touches them
	always_comb begin
		next_sel_en = sel_en;
		next_pattern = pattern;
		next_mask = mask;
		// Writes land in the data phase, when hwdata is on the bus
		if (dph_valid && dph.wr) begin
			if (hit(dph.addr, `SP_OFF_CTRL)) begin
				next_sel_en = hwdata[`SP_CTRL_SEL_EN_BIT];
			end
			if (hit(dph.addr, `SP_OFF_CARE)) begin
				next_pattern.care = hwdata[14:0];
			end
			if (hit(dph.addr, `SP_OFF_VALUE)) begin
				next_pattern.value = hwdata[14:0];
			end
			if (hit(dph.addr, `SP_OFF_MASK)) begin
				next_mask = hwdata[`SP_ST_WIDTH-1:0];
			end
		end
	end

	// Power-on reset is the only thing that reloads the operator settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_en <= `SP_CTRL_RST;
			pattern.care <= `SP_CARE_RST;
			pattern.value <= `SP_VALUE_RST;
			mask <= `SP_MASK_RST;
		end else begin
			sel_en <= next_sel_en;
			pattern <= next_pattern;
			mask <= next_mask;
		end
	end

	// ------------------------------------------------------------
	// Status, flag and interrupt
	// ------------------------------------------------------------

	logic [`SP_ST_WIDTH-1:0] next_status;
	logic [`SP_ST_WIDTH-1:0] set_bits;
	logic [`SP_ST_WIDTH-1:0] clr_bits;
	logic [14:0] next_last_blocked;
	logic next_illegal_lamp;
	logic next_irq;
	logic sense_clr;
	logic op_clr;

	// Set beats clear, so an illegal write landing on a sense is not lost
	// Bit 6 records an auto load or auto dump start for the program
	always_comb begin
		set_bits = '0;
		set_bits[`SP_ST_ILLEGAL_BIT] = blocked;
		set_bits[`SP_ST_FORCE_BIT] = force_evt;
		clr_bits = '0;
		if (dph_valid && hit(dph.addr, `SP_OFF_STATUS)) begin
			clr_bits = hwdata[`SP_ST_WIDTH-1:0];
		end
		// A status read is the program sensing the flag
		sense_clr = rd_take && hit(haddr, `SP_OFF_STATUS);
		// Console master clear and internal clear touch the flag only
		op_clr = master_clear || internal_clear;
		if (sense_clr) begin
			clr_bits[`SP_ST_ILLEGAL_BIT] = 1'b1;
		end
		if (op_clr) begin
			clr_bits[`SP_ST_ILLEGAL_BIT] = 1'b1;
		end
		next_status = (status & ~clr_bits) | set_bits;
		next_last_blocked = blocked ? adj_addr : last_blocked;
		next_illegal_lamp = next_status[`SP_ST_ILLEGAL_BIT];
		next_irq = |(next_status & mask);
	end

	// Lamp and interrupt come straight from flops, a cycle after the event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= '0;
			last_blocked <= 15'h0000;
			illegal_lamp <= 1'b0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			last_blocked <= next_last_blocked;
			illegal_lamp <= next_illegal_lamp;
			irq <= next_irq;
		end
	end

endmodule

// ---- dv/stor_requester.sv ----
// ------------------------------------------------
// Processor storage requester model
// ------------------------------------------------
module stor_requester (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic go, // Issue one request
	input wire logic wr, // Write request
	input wire logic [14:0] addr, // Word address
	output storage_protect_pkg::stor_req_t req // Request bus
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle cycles show the inverted address so a stale copy never looks valid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			req <= '0;
		else if (go)
			req <= {1'b1, wr, addr};
		else
			req <= {2'b00, ~req.addr};
	end
endmodule

// ---- dv/storage_protect_monitor.sv ----
module storage_protect_monitor (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset
	input wire storage_protect_pkg::stor_req_t stor_in, // Request
	input wire logic int_seq, // Interrupt sequence
	input wire logic [1:0] cap_sel, // Capacity
	input wire logic auto_enter, // Top unlock
	input wire logic auto_load, // Load switch
	input wire logic auto_dump, // Dump switch
	input wire logic master_clear, // Clear
	input wire logic internal_clear, // Clear
	input wire storage_protect_pkg::stor_req_t stor_out, // To storage
	input wire logic illegal_lamp, // Flag
	input wire logic p_force_valid, // Force pulse
	input wire logic [14:0] p_force_addr // Forced address
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [14:0] msk;
	logic [14:0] fa;
	logic wr;
	logic top;
	logic sav;
	// ------------------------------------------------
	// Folded address and protected-set decode
	// ------------------------------------------------
	assign msk = (cap_sel == 2'h0) ? 15'h1fff : (cap_sel == 2'h1) ? 15'h3fff : 15'h7fff;
	assign fa = stor_in.addr & msk;
	assign wr = stor_in.valid & stor_in.write;
	assign top = &(fa[14:5] | ~msk[14:5]);
	assign sav = fa inside {15'h2, 15'h3, 15'h4, 15'h5, 15'h8, 15'h9};
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence top_wr_s;
		wr && top && !auto_enter;
	endsequence
	sequence dropped_s;
		!stor_out.write && illegal_lamp;
	endsequence
	// Guard on past reset: outputs still hold reset values one edge after release
	fold_addr_a: assert property ($past(hresetn) |-> stor_out.addr == $past(fa))
		else $error("folded address wrong");
	valid_pass_a: assert property ($past(hresetn) |-> stor_out.valid == $past(stor_in.valid))
		else $error("request lost");
	no_new_wr_a: assert property (stor_out.write |-> $past(wr))
		else $error("write invented");
	top_block_a: assert property (top_wr_s |=> dropped_s)
		else $error("top block write passed");
	save_free_a: assert property (wr && int_seq && sav |=> stor_out.write)
		else $error("save write blocked");
	flag_clear_a: assert property ((master_clear || internal_clear) && !wr |=> !illegal_lamp)
		else $error("flag not cleared");
	flag_cause_a: assert property ($rose(illegal_lamp) |-> $past(wr) && !stor_out.write)
		else $error("flag without blocked write");
	load_force_a: assert property ($rose(auto_load) |=> p_force_valid && p_force_addr == 15'h7fe0)
		else $error("load start wrong");
	dump_force_a: assert property ($rose(auto_dump) && !$rose(auto_load)
		|=> p_force_valid && p_force_addr == 15'h7ff0)
		else $error("dump start wrong");
	force_pulse_a: assert property (p_force_valid |=> !p_force_valid)
		else $error("force pulse too long");
endmodule

bind storage_protect storage_protect_monitor mon (.hclk, .hresetn, .stor_in, .int_seq, .cap_sel,
	.auto_enter, .auto_load, .auto_dump, .master_clear, .internal_clear, .stor_out,
	.illegal_lamp, .p_force_valid, .p_force_addr);

// ---- dv/storage_protect_tb_top.sv ----
`include "storage_protect_map.svh"

module storage_protect_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hready, hresp, go, rw, int_seq, console_disable, auto_enter;
	logic auto_load, auto_dump, master_clear, internal_clear, illegal_lamp, p_force_valid, irq;
	logic [1:0] htrans, cap_sel;
	logic [2:0] hsize;
	logic [11:0] haddr;
	logic [14:0] ra, p_force_addr, tp, mk;
	logic [15:0] cw;
	logic [31:0] hwdata, hrdata, q;
	storage_protect_pkg::stor_req_t stor_in, stor_out;
	logic [11:0] offs [6] = '{`SP_OFF_CTRL, `SP_OFF_CARE, `SP_OFF_VALUE, `SP_OFF_STATUS,
		`SP_OFF_MASK, 12'h018};
	logic [14:0] t_c [5] = '{15'h7fff, 15'h7fff, 15'h7ffd, 15'h7ffd, 15'h0};
	logic [14:0] t_v [5] = '{15'hf, 15'hf, 15'h10, 15'h10, 15'h0};
	logic [14:0] t_a [5] = '{15'hf, 15'he, 15'h12, 15'h14, 15'h1234};
	logic t_w [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [14:0] sv [6] = '{15'h2, 15'h3, 15'h4, 15'h5, 15'h8, 15'h9};
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	// ------------------------------------------------
	// Clock, design and requester
	// ------------------------------------------------
	always #50 hclk = ~hclk;
	storage_protect uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout(hready), .hresp, .stor_in, .int_seq, .cap_sel,
		.console_disable, .auto_enter, .auto_load, .auto_dump, .master_clear,
		.internal_clear, .stor_out, .illegal_lamp, .p_force_valid, .p_force_addr, .irq);
	stor_requester req_model (.hclk, .hresetn, .go, .wr(rw), .addr(ra), .req(stor_in));
	// ------------------------------------------------
	// Verdict, compare and access tasks
	// ------------------------------------------------
	task stop_test;
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus transfer; the data phase is held until ready, read data lands in q
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk) begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= w;
			haddr <= a;
		end
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	// One storage cycle; the result shows one edge after the requester drives it
	task st(input logic w, input logic [14:0] a, input logic ew, input logic [14:0] ea);
		@(posedge hclk) begin
			go <= 1'b1;
			rw <= w;
			ra <= a;
		end
		@(posedge hclk) go <= 1'b0;
		@(posedge hclk) #1;
		cmp(stor_out, {1'b1, ew, ea});
	endtask
	// Hang guard, far above the few hundred cycles the sequence needs
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			stop_test;
		end
	end
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, go, rw, int_seq, console_disable, auto_enter} = '0;
		{auto_load, auto_dump, master_clear, internal_clear, htrans, haddr, hwdata, ra} = '0;
		hsize = 3'h2;
		cap_sel = 2'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			bus(1'b0, offs[k], 32'h0);
			cmp(q, 32'h0);
		end
		bus(1'b0, `SP_OFF_INFO, 32'h0);
		cmp(q, 32'h00020000);
		bus(1'b1, `SP_OFF_MASK, 32'h20);
		for (int k = 0; k < 3; k++) begin
			@(posedge hclk) cap_sel <= k[1:0];
			cw = 16'h2000 << k;
			tp = cw[14:0] - 15'h20;
			mk = cw[14:0] - 15'h1;
			st(1'b1, tp, 1'b0, tp);
			st(1'b1, tp - 15'h1, 1'b1, tp - 15'h1);
			st(1'b1, 15'h6ee4, 1'b1, 15'h6ee4 & mk);
		end
		cmp({illegal_lamp, irq}, 2'b11);
		cmp(hresp, 1'b0);
		bus(1'b0, `SP_OFF_STATUS, 32'h0);
		cmp(q, 32'h20);
		bus(1'b0, `SP_OFF_STATUS, 32'h0);
		cmp(q, 32'h0);
		cmp({illegal_lamp, irq}, 2'b00);
		st(1'b0, 15'h7fe0, 1'b0, 15'h7fe0);
		cmp(illegal_lamp, 1'b0);
		@(posedge hclk) auto_enter <= 1'b1;
		st(1'b1, 15'h7fe0, 1'b1, 15'h7fe0);
		@(posedge hclk) auto_enter <= 1'b0;
		bus(1'b1, `SP_OFF_CTRL, 32'h1);
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, `SP_OFF_CARE, {17'h0, t_c[k]});
			bus(1'b1, `SP_OFF_VALUE, {17'h0, t_v[k]});
			st(1'b1, t_a[k], t_w[k], t_a[k]);
		end
		@(posedge hclk) int_seq <= 1'b1;
		for (int k = 0; k < 6; k++)
			st(1'b1, sv[k], 1'b1, sv[k]);
		st(1'b1, 15'h6, 1'b0, 15'h6);
		@(posedge hclk) begin
			int_seq <= 1'b0;
			console_disable <= 1'b1;
		end
		st(1'b1, 15'h1234, 1'b1, 15'h1234);
		st(1'b1, 15'h7fe0, 1'b0, 15'h7fe0);
		@(posedge hclk) console_disable <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			st(1'b1, 15'h1234, 1'b0, 15'h1234);
			@(posedge hclk) begin
				master_clear <= (k == 0);
				internal_clear <= (k == 1);
			end
			@(posedge hclk) begin
				master_clear <= 1'b0;
				internal_clear <= 1'b0;
			end
			@(posedge hclk) #1;
			cmp(illegal_lamp, 1'b0);
		end
		bus(1'b1, `SP_OFF_MASK, 32'h0);
		st(1'b1, 15'h1234, 1'b0, 15'h1234);
		cmp({illegal_lamp, irq}, 2'b10);
		bus(1'b1, `SP_OFF_STATUS, 32'h20);
		#1;
		cmp(illegal_lamp, 1'b0);
		for (int k = 0; k < 2; k++) begin
			@(posedge hclk) begin
				auto_load <= (k == 0);
				auto_dump <= (k == 1);
			end
			@(posedge hclk) #1;
			cmp({p_force_valid, p_force_addr}, k ? 16'hfff0 : 16'hffe0);
			@(posedge hclk) begin
				auto_load <= 1'b0;
				auto_dump <= 1'b0;
			end
			#1;
			cmp(p_force_valid, 1'b0);
		end
		bus(1'b0, `SP_OFF_STATUS, 32'h0);
		cmp(q, 32'h40);
		bus(1'b1, `SP_OFF_STATUS, 32'h40);
		bus(1'b0, `SP_OFF_STATUS, 32'h0);
		cmp(q, 32'h0);
		stop_test;
	end
endmodule
